// [hw/loc_top.sv]
// Top of the logic output conditioning block with its Avalon-MM registers.
// Operation
// - Output turns on only after the full turn-on delay, up to 60000 ms.
// - Turn-on delay is zero for fault, brake, output, precharge, line duty.
// - Output turns off only after the full holding time, up to 9999 ms.
// - Holding time is zero for fault, brake, precharge and line duty.
// - Positive polarity drives 1 when true; negative drives 0 when true.
// - Polarity is locked positive for fault, brake, precharge, line duty.
// - Third output and its settings exist only with the extension card.
// - Second and third outputs share the first's choices; default none.
// - Choices include brake, line, output, end reel, wobble, precharge.
`timescale 1ns/10ps
`default_nettype none
module loc_top (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [loc_pkg::NUM_SRC-1:0] cond_src_in,
  input wire logic card_present_in,
  output logic logic_output_second_out,
  output logic logic_output_third_out
);
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [7:0] asg2_q, asg2_d, asg3_q, asg3_d;
  logic [15:0] dly2_q, dly2_d, dly3_q, dly3_d;
  logic [15:0] hld2_q, hld2_d, hld3_q, hld3_d;
  logic pol2_q, pol2_d, pol3_q, pol3_d;
  logic [2:0] card_sync_q;
  logic card_q, card_d;
  logic [17:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic [1:0] cond_q, cond_d;
  logic lvl2, lvl3;
  logic out2_q, out3_q;

  // Maps an assignment code to its condition source; none and codes of NUM_SRC and above are false.
  function automatic logic pick_cond(input logic [7:0] a,
                                     input logic [loc_pkg::NUM_SRC-1:0] s);
    pick_cond = (a < 8'(loc_pkg::NUM_SRC)) && (a != loc_pkg::ASG_NONE) ?
      s[a[4:0]] : 1'b0;
  endfunction : pick_cond

  // Writes one register, honouring byte enables, and clamps to the range.
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be,
                                       input logic [15:0] lim);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    wr16 = (v > lim) ? lim : v;
  endfunction : wr16

  // Rejects codes outside the defined choices so software reads back none.
  function automatic logic [7:0] legal_asg(input logic [7:0] a);
    legal_asg = (a <= loc_pkg::ASG_PRECHARGE) ? a : loc_pkg::ASG_NONE;
  endfunction : legal_asg

  // Millisecond time base.
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 18'h00001;
    if (tick_cnt_q == 18'(loc_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_d = 18'h00000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // The card-present pin is asynchronous; it must agree on two stages.
  always_comb begin
    card_d = card_q;
    if (card_sync_q[1] == card_sync_q[2]) begin
      card_d = card_sync_q[2];
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      card_sync_q <= 3'h0;
      card_q <= 1'b0;
    end else begin
      card_sync_q <= {card_sync_q[1:0], card_present_in};
      card_q <= card_d;
    end
  end

  // Condition selection is registered so both channels see a clean level.
  always_comb begin
    cond_d[0] = pick_cond(asg2_q, cond_src_in);
    cond_d[1] = card_q && pick_cond(asg3_q, cond_src_in);
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cond_q <= 2'h0;
    end else begin
      cond_q <= cond_d;
    end
  end

  // Register file. Read data is fetched a cycle early; a write lands only on
  // the edge at which the master sees waitrequest low.
  always_comb begin
    asg2_d = asg2_q;
    asg3_d = asg3_q;
    dly2_d = dly2_q;
    dly3_d = dly3_q;
    hld2_d = hld2_q;
    hld3_d = hld3_q;
    pol2_d = pol2_q;
    pol3_d = pol3_q;
    rdata_d = 32'h00000000;
    ack_d = (avs_read || avs_write) && !ack_q;
    if (avs_write && ack_q) begin
      case (avs_address)
        loc_pkg::ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            pol2_d = avs_writedata[loc_pkg::CTRL_POL2_BIT];
            if (card_q) begin
              pol3_d = avs_writedata[loc_pkg::CTRL_POL3_BIT];
            end
          end
        end
        loc_pkg::ADDR_ASSIGN2: begin
          if (avs_byteenable[0]) begin
            asg2_d = legal_asg(avs_writedata[7:0]);
          end
        end
        loc_pkg::ADDR_DELAY2: begin
          dly2_d = wr16(dly2_q, avs_writedata, avs_byteenable,
                        loc_pkg::DELAY_MAX_MS);
        end
        loc_pkg::ADDR_HOLD2: begin
          hld2_d = wr16(hld2_q, avs_writedata, avs_byteenable,
                        loc_pkg::HOLD_MAX_MS);
        end
        loc_pkg::ADDR_ASSIGN3: begin
          if (avs_byteenable[0] && card_q) begin
            asg3_d = legal_asg(avs_writedata[7:0]);
          end
        end
        loc_pkg::ADDR_DELAY3: begin
          if (card_q) begin
            dly3_d = wr16(dly3_q, avs_writedata, avs_byteenable,
                          loc_pkg::DELAY_MAX_MS);
          end
        end
        loc_pkg::ADDR_HOLD3: begin
          if (card_q) begin
            hld3_d = wr16(hld3_q, avs_writedata, avs_byteenable,
                          loc_pkg::HOLD_MAX_MS);
          end
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
    if (avs_read && !ack_q) begin
      case (avs_address)
        loc_pkg::ADDR_CTRL: begin
          rdata_d[loc_pkg::CTRL_POL2_BIT] = pol2_q;
          rdata_d[loc_pkg::CTRL_POL3_BIT] = card_q & pol3_q;
        end
        loc_pkg::ADDR_ASSIGN2: rdata_d[7:0] = asg2_q;
        loc_pkg::ADDR_DELAY2: rdata_d[15:0] = dly2_q;
        loc_pkg::ADDR_HOLD2: rdata_d[15:0] = hld2_q;
        loc_pkg::ADDR_ASSIGN3: rdata_d[7:0] = card_q ? asg3_q : 8'h00;
        loc_pkg::ADDR_DELAY3: rdata_d[15:0] = card_q ? dly3_q : 16'h0000;
        loc_pkg::ADDR_HOLD3: rdata_d[15:0] = card_q ? hld3_q : 16'h0000;
        loc_pkg::ADDR_STATUS: begin
          rdata_d[loc_pkg::STAT_OUT2_BIT] = out2_q;
          rdata_d[loc_pkg::STAT_OUT3_BIT] = out3_q;
          rdata_d[loc_pkg::STAT_CARD_BIT] = card_q;
          rdata_d[loc_pkg::STAT_COND2_BIT] = cond_q[0];
          rdata_d[loc_pkg::STAT_COND3_BIT] = cond_q[1];
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      asg2_q <= loc_pkg::ASSIGN_RESET;
      asg3_q <= loc_pkg::ASSIGN_RESET;
      dly2_q <= loc_pkg::DELAY_RESET;
      dly3_q <= loc_pkg::DELAY_RESET;
      hld2_q <= loc_pkg::HOLD_RESET;
      hld3_q <= loc_pkg::HOLD_RESET;
      pol2_q <= loc_pkg::POL_RESET;
      pol3_q <= loc_pkg::POL_RESET;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      asg2_q <= asg2_d;
      asg3_q <= asg3_d;
      dly2_q <= dly2_d;
      dly3_q <= dly3_d;
      hld2_q <= hld2_d;
      hld3_q <= hld3_d;
      pol2_q <= pol2_d;
      pol3_q <= pol3_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  loc_channel u_ch2 (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .tick_in(tick_q),
    .cond_in(cond_q[0]),
    .assign_in(asg2_q),
    .delay_in(dly2_q),
    .hold_in(hld2_q),
    .active_low_polarity_in(pol2_q),
    .level_out(lvl2)
  );

  loc_channel u_ch3 (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .tick_in(tick_q),
    .cond_in(cond_q[1]),
    .assign_in(card_q ? asg3_q : loc_pkg::ASG_NONE),
    .delay_in(dly3_q),
    .hold_in(hld3_q),
    .active_low_polarity_in(card_q & pol3_q),
    .level_out(lvl3)
  );

  // Without the card the third output is held low whatever its polarity.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out2_q <= 1'b0;
      out3_q <= 1'b0;
    end else begin
      out2_q <= lvl2;
      out3_q <= card_q & lvl3;
    end
  end

  assign logic_output_second_out = out2_q;
  assign logic_output_third_out = out3_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
endmodule : loc_top
`default_nettype wire

// [hw/loc_pkg.sv]
// Package with register map, assignment codes and timing constants.
package loc_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] DELAY_MAX_MS = 16'hea60;
  localparam logic [15:0] HOLD_MAX_MS = 16'h270f;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [7:0] ASSIGN_RESET = 8'h00;
  localparam logic POL_RESET = 1'b0;
  // Register word addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ASSIGN2 = 4'h1;
  localparam logic [3:0] ADDR_DELAY2 = 4'h2;
  localparam logic [3:0] ADDR_HOLD2 = 4'h3;
  localparam logic [3:0] ADDR_ASSIGN3 = 4'h4;
  localparam logic [3:0] ADDR_DELAY3 = 4'h5;
  localparam logic [3:0] ADDR_HOLD3 = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  // Control register fields.
  localparam int unsigned CTRL_POL2_BIT = 0;
  localparam int unsigned CTRL_POL3_BIT = 1;
  // Status register fields.
  localparam int unsigned STAT_OUT2_BIT = 0;
  localparam int unsigned STAT_OUT3_BIT = 1;
  localparam int unsigned STAT_CARD_BIT = 2;
  localparam int unsigned STAT_COND2_BIT = 3;
  localparam int unsigned STAT_COND3_BIT = 4;
  // Assignment codes: 0 none, 1..15 general conditions, then specials.
  localparam logic [7:0] ASG_NONE = 8'h00;
  localparam logic [7:0] ASG_FAULT = 8'h10;
  localparam logic [7:0] ASG_BRAKE = 8'h11;
  localparam logic [7:0] ASG_LINE = 8'h12;
  localparam logic [7:0] ASG_OUTPUT = 8'h13;
  localparam logic [7:0] ASG_END_REEL = 8'h14;
  localparam logic [7:0] ASG_WOBBLE = 8'h15;
  localparam logic [7:0] ASG_PRECHARGE = 8'h16;
  localparam int unsigned NUM_SRC = 32;
endpackage : loc_pkg

// [hw/loc_channel.sv]
// One conditioned logic output: delay, holding time and polarity.
`timescale 1ns/10ps
`default_nettype none
module loc_channel (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic tick_in,
  input wire logic cond_in,
  input wire logic [7:0] assign_in,
  input wire logic [15:0] delay_in,
  input wire logic [15:0] hold_in,
  input wire logic active_low_polarity_in,
  output logic level_out
);
  typedef enum logic [3:0] {
    LOC_OFF = 4'b0001,
    LOC_ON_WAIT = 4'b0010,
    LOC_ON = 4'b0100,
    LOC_OFF_WAIT = 4'b1000
  } loc_state_t;

  function automatic logic is_safety(input logic [7:0] a, input logic output_contactor_select);
    is_safety = (a == loc_pkg::ASG_FAULT) || (a == loc_pkg::ASG_BRAKE) ||
      (a == loc_pkg::ASG_PRECHARGE) || (a == loc_pkg::ASG_LINE) ||
      (output_contactor_select && (a == loc_pkg::ASG_OUTPUT));
  endfunction : is_safety

  loc_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic level_q, level_d;
  logic [15:0] eff_delay, eff_hold;
  logic eff_neg;

  always_comb begin
    eff_delay = is_safety(assign_in, 1'b1) ? 16'h0000 : delay_in;
    eff_hold = is_safety(assign_in, 1'b0) ? 16'h0000 : hold_in;
    eff_neg = is_safety(assign_in, 1'b0) ? 1'b0 : active_low_polarity_in;
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      LOC_OFF: begin
        if (cond_in) begin
          cnt_d = 16'h0000;
          state_d = (eff_delay == 16'h0000) ? LOC_ON : LOC_ON_WAIT;
        end
      end
      LOC_ON_WAIT: begin
        if (!cond_in) begin
          state_d = LOC_OFF;
        end else if (tick_in) begin
          cnt_d = cnt_q + 16'h0001;
          // Strictly greater, so a part tick at the start never shortens it.
          if (cnt_d > eff_delay) begin
            state_d = LOC_ON;
          end
        end
      end
      LOC_ON: begin
        if (!cond_in) begin
          cnt_d = 16'h0000;
          state_d = (eff_hold == 16'h0000) ? LOC_OFF : LOC_OFF_WAIT;
        end
      end
      LOC_OFF_WAIT: begin
        if (cond_in) begin
          state_d = LOC_ON;
        end else if (tick_in) begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_d > eff_hold) begin
            state_d = LOC_OFF;
          end
        end
      end
      default: begin
        state_d = LOC_OFF;
        cnt_d = 16'h0000;
      end
    endcase
    level_d = ((state_d == LOC_ON) || (state_d == LOC_OFF_WAIT)) ^ eff_neg;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= LOC_OFF;
      cnt_q <= 16'h0000;
      level_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule : loc_channel
`default_nettype wire

// [verif/loc_top_chk.sv]
// Checker of bus timing and output conditioning at the block's top ports.
`timescale 1ns/10ps
`default_nettype none
module loc_top_chk (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [loc_pkg::NUM_SRC-1:0] cond_src_in,
  input wire logic card_present_in,
  input wire logic logic_output_second_out,
  input wire logic logic_output_third_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic brk_q;
  logic brk_d;
  logic req;
  assign req = avs_read || avs_write;
  // Shadow of the brake assignment, so safety checks need no internals.
  always_comb begin
    brk_d = brk_q;
    if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
        avs_address == loc_pkg::ADDR_ASSIGN2) begin
      brk_d = avs_writedata[7:0] == loc_pkg::ASG_BRAKE;
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brk_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
    end
  end
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  // Seven cycles cover the card synchroniser and the output register.
  sequence s_card_gone;
    !card_present_in [*7];
  endsequence
  property p_brk(logic v);
    (brk_q && cond_src_in[loc_pkg::ASG_BRAKE] == v) [*6]
      |-> logic_output_second_out == v;
  endproperty
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  chk_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  chk_unmapped_rd: assert property (s_rd ##0 avs_address[3]
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_reset_quiet: assert property (
    $rose(resetn_in) |-> !logic_output_second_out && !logic_output_third_out)
    else $error("output active after reset");
  chk_card_out: assert property (
    s_card_gone |-> !logic_output_third_out)
    else $error("third output active without card");
  chk_card_read: assert property (
    s_card_gone ##0 s_rd ##0 (avs_address >= loc_pkg::ADDR_ASSIGN3 &&
    avs_address <= loc_pkg::ADDR_HOLD3) |-> avs_readdata == 32'h0)
    else $error("third output setting visible without card");
  chk_brake_on: assert property (p_brk(1'b1))
    else $error("brake output not on at once");
  chk_brake_off: assert property (p_brk(1'b0))
    else $error("brake output not off at once");
endmodule : loc_top_chk
bind loc_top loc_top_chk chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cond_src_in(cond_src_in), .card_present_in(card_present_in),
  .logic_output_second_out(logic_output_second_out),
  .logic_output_third_out(logic_output_third_out));
`default_nettype wire

// [verif/loc_load.sv]
// Model of a contactor coil driven by one conditioned output.
`timescale 1ns/10ps
`default_nettype none
module loc_load (
  input wire logic mclk_in,
  input wire logic coil_in,
  output logic [7:0] pulls_out
);
  logic last_q = 1'b0;
  logic [7:0] pulls_q = 8'h00;
  // Counting pick-ups shows a short glitch that a level check misses.
  always @(posedge mclk_in) begin
    last_q <= coil_in;
    if (coil_in === 1'b1 && last_q === 1'b0) begin
      pulls_q <= pulls_q + 8'h01;
    end
  end
  assign pulls_out = pulls_q;
endmodule : loc_load
`default_nettype wire

// [verif/test_logic_output_conditioning.sv]
// Self-checking bench for the logic output conditioning block.
`timescale 1ns/10ps
`default_nettype none
module test_logic_output_conditioning;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic wait_s;
  logic [31:0] src = 32'h0;
  logic card = 1'b1;
  logic o2;
  logic o3;
  logic [7:0] pulls;
  logic [7:0] pulls0;
  logic [31:0] got;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  loc_top uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wait_s), .cond_src_in(src),
    .card_present_in(card), .logic_output_second_out(o2),
    .logic_output_third_out(o3));
  loc_load load (.mclk_in(mclk_in), .coil_in(o2), .pulls_out(pulls));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic finish_test();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // A hang anywhere ends the run here.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    adr <= a;
    wd <= d;
    be <= 4'h3;
    wr <= w;
    rd <= !w;
    do @(posedge mclk_in); while (wait_s !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(got, e);
  endtask : rdc
  task automatic lv(input int n, input logic e2, input logic e3);
    repeat (n) @(posedge mclk_in);
    check({30'h0, o2, o3}, {30'h0, e2, e3});
  endtask : lv
  initial begin
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    for (int a = 0; a < 7; a++) rdc(a[3:0], 32'h0);
    rdc(loc_pkg::ADDR_STATUS, 32'h4);
    bus(1'b1, 4'h8, 32'h1);
    rdc(4'h8, 32'h0);
    bus(1'b1, loc_pkg::ADDR_DELAY2, 32'hffff);
    rdc(loc_pkg::ADDR_DELAY2, 32'hea60);
    bus(1'b1, loc_pkg::ADDR_HOLD2, 32'hffff);
    rdc(loc_pkg::ADDR_HOLD2, 32'h270f);
    bus(1'b1, loc_pkg::ADDR_DELAY2, 32'h0);
    bus(1'b1, loc_pkg::ADDR_HOLD2, 32'h0);
    bus(1'b1, loc_pkg::ADDR_ASSIGN2, 32'h17);
    rdc(loc_pkg::ADDR_ASSIGN2, 32'h0);
    for (int c = 1; c <= 22; c++) begin
      bus(1'b1, loc_pkg::ADDR_ASSIGN2, c[31:0]);
      bus(1'b1, loc_pkg::ADDR_ASSIGN3, c[31:0]);
      src <= 32'h1 << c;
      lv(8, 1'b1, 1'b1);
      src <= 32'h0;
      lv(8, 1'b0, 1'b0);
    end
    bus(1'b1, loc_pkg::ADDR_ASSIGN2, 32'h1);
    bus(1'b1, loc_pkg::ADDR_CTRL, 32'h1);
    lv(8, 1'b1, 1'b0);
    src <= 32'h2;
    lv(8, 1'b0, 1'b0);
    bus(1'b1, loc_pkg::ADDR_ASSIGN2, 32'h11);
    bus(1'b1, loc_pkg::ADDR_DELAY2, 32'hea60);
    bus(1'b1, loc_pkg::ADDR_HOLD2, 32'h270f);
    lv(8, 1'b0, 1'b0);
    src <= 32'h0002_0000;
    lv(8, 1'b1, 1'b0);
    src <= 32'h0;
    lv(8, 1'b0, 1'b0);
    bus(1'b1, loc_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, loc_pkg::ADDR_HOLD2, 32'h0);
    bus(1'b1, loc_pkg::ADDR_ASSIGN2, 32'h1);
    pulls0 = pulls;
    src <= 32'h2;
    lv(200, 1'b0, 1'b0);
    src <= 32'h0;
    lv(50, 1'b0, 1'b0);
    check({24'h0, pulls}, {24'h0, pulls0});
    card <= 1'b0;
    lv(10, 1'b0, 1'b0);
    src <= 32'h0040_0000;
    lv(8, 1'b0, 1'b0);
    rdc(loc_pkg::ADDR_ASSIGN3, 32'h0);
    bus(1'b1, loc_pkg::ADDR_HOLD3, 32'h5);
    rdc(loc_pkg::ADDR_HOLD3, 32'h0);
    bus(1'b0, loc_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, got[2]}, 32'h0);
    // Output contactor duty drops only the turn-on delay.
    bus(1'b1, loc_pkg::ADDR_HOLD2, 32'h270f);
    bus(1'b1, loc_pkg::ADDR_ASSIGN2, 32'h13);
    src <= 32'h0008_0000;
    lv(8, 1'b1, 1'b0);
    rdc(loc_pkg::ADDR_STATUS, 32'h9);
    src <= 32'h0;
    lv(200, 1'b1, 1'b0);
    // A reset in mid-run must clear the outputs and the settings.
    resetn_in <= 1'b0;
    lv(2, 1'b0, 1'b0);
    resetn_in <= 1'b1;
    rdc(loc_pkg::ADDR_HOLD2, 32'h0);
    rdc(loc_pkg::ADDR_ASSIGN2, 32'h0);
    finish_test();
  end
endmodule : test_logic_output_conditioning
`default_nettype wire
